// ==== rtl/spl_link_startup.sv ====
/*
  Link startup control of a single-pair 100 Mbit PHY: link enable gating,
  master/slave training sequence, link stability flags, link-up and
  training-failure events, slave polarity detection, management registers.
  Assumes receiver status, idle sync and polarity inputs come from PCS logic
  on core_clk_in; the management clock and data arrive from pins.
*/
`include "spl_cfg.svh"

module spl_link_startup #(
  parameter int unsigned AUTO_EN_CYCLES =
    `SPL_AUTO_EN_DELAY_MS * (`SPL_CLK_HZ / 1000),
  parameter int unsigned MINWAIT_CYCLES = `SPL_MINWAIT_CYCLES,
  parameter int unsigned MAXWAIT_CYCLES = `SPL_MAXWAIT_CYCLES
)
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire logic [4:0] phy_addr_in,
  // power mode and receiver status
  input wire logic normal_mode_in,
  input wire logic rx_idle_sync_in,
  input wire logic loc_rcvr_ok_in,
  input wire logic rem_rcvr_ok_in,
  input wire logic descrambler_locked_in,
  input wire logic polarity_inverted_in,
  // link control
  output spl_pkg::spl_tx_mode_e tx_mode_out,
  output logic polarity_correct_out,
  output logic link_up_out,
  output logic link_up_event_out,
  output logic training_failure_event_out
);
  import spl_pkg::*;

  if (AUTO_EN_CYCLES < 1 || MINWAIT_CYCLES < 1 || MAXWAIT_CYCLES <= MINWAIT_CYCLES)
  begin : g_param_check
    $error("spl_link_startup: timer counts out of range");
  end

  logic mdc_meta_reg, mdc_sync_reg, mdc_prev_reg;
  logic mdio_meta_reg, mdio_sync_reg;
  logic [4:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic [15:0] rd_data;

  logic link_en_reg, master_reg, autonomous_reg;
  logic normal_prev_reg, auto_busy_reg, auto_set;
  logic [31:0] auto_cnt_reg;
  spl_state_e state_reg, state_next;
  logic [31:0] wait_cnt_reg;
  logic train_fail;
  logic loc_flag_reg, rem_flag_reg, scr_flag_reg;

  // register read word, reserved bits and unmapped addresses read zero
  function automatic logic [15:0] read_word(input logic [4:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    if (addr == `SPL_REG_EXT_CTRL)
    begin
      w[`SPL_EXT_LINK_EN_BIT] = link_en_reg;
      w[`SPL_EXT_MASTER_BIT] = master_reg;
      w[`SPL_EXT_AUTONOMOUS_BIT] = autonomous_reg;
    end
    else if (addr == `SPL_REG_COMM_STAT)
    begin
      w[`SPL_STAT_LINK_UP_BIT] = link_up_out;
      w[`SPL_STAT_LOC_OK_BIT] = loc_flag_reg;
      w[`SPL_STAT_REM_OK_BIT] = rem_flag_reg;
      w[`SPL_STAT_SCR_BIT] = scr_flag_reg;
      w[`SPL_STAT_POL_BIT] = polarity_correct_out;
    end
    return w;
  endfunction

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mdc_meta_reg <= 1'b0;
      mdc_sync_reg <= 1'b0;
      mdc_prev_reg <= 1'b0;
      mdio_meta_reg <= 1'b1;
      mdio_sync_reg <= 1'b1;
    end
    else
    begin
      mdc_meta_reg <= mdc_in;
      mdc_sync_reg <= mdc_meta_reg;
      mdc_prev_reg <= mdc_sync_reg;
      mdio_meta_reg <= mdio_in;
      mdio_sync_reg <= mdio_meta_reg;
    end
  end

  // a process, not an assign: the word must follow the flags, not only the address
  always_comb
  begin
    rd_data = read_word(reg_addr);
  end

  spl_smi_slave u_smi (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .mdc_rise_in(mdc_sync_reg && !mdc_prev_reg),
    .mdio_bit_in(mdio_sync_reg),
    .phy_addr_in(phy_addr_in),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out),
    .rd_data_in(rd_data),
    .reg_addr_out(reg_addr),
    .wr_data_out(wr_data),
    .wr_stb_out(wr_stb)
  );

  // delay from entering normal mode to the autonomous link enable
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      normal_prev_reg <= 1'b0;
      auto_busy_reg <= 1'b0;
      auto_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      normal_prev_reg <= normal_mode_in;
      if (!normal_mode_in)
      begin
        auto_busy_reg <= 1'b0;
        auto_cnt_reg <= 32'h0000_0000;
      end
      else if (!normal_prev_reg)
      begin
        auto_busy_reg <= 1'b1;
        auto_cnt_reg <= 32'h0000_0000;
      end
      else if (auto_busy_reg)
      begin
        auto_cnt_reg <= auto_cnt_reg + 32'h0000_0001;
        if (auto_cnt_reg == AUTO_EN_CYCLES - 1)
        begin
          auto_busy_reg <= 1'b0;
        end
      end
    end
  end

  assign auto_set = auto_busy_reg && auto_cnt_reg == AUTO_EN_CYCLES - 1 && autonomous_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      link_en_reg <= `SPL_RST_LINK_EN;
      master_reg <= `SPL_RST_MASTER;
      autonomous_reg <= `SPL_RST_AUTONOMOUS;
    end
    else
    begin
      if (wr_stb && reg_addr == `SPL_REG_EXT_CTRL)
      begin
        link_en_reg <= wr_data[`SPL_EXT_LINK_EN_BIT];
        master_reg <= wr_data[`SPL_EXT_MASTER_BIT];
        autonomous_reg <= wr_data[`SPL_EXT_AUTONOMOUS_BIT];
      end
      // the autonomous set wins over a clearing write in the same cycle
      if (auto_set)
      begin
        link_en_reg <= 1'b1;
      end
    end
  end

  // role only steers the startup sequence; data path is duplex either way
  always_comb
  begin
    state_next = state_reg;
    train_fail = 1'b0;
    case (state_reg)
      SPL_ST_DISABLE:
      begin
        if (link_en_reg && (master_reg || rx_idle_sync_in))
        begin
          state_next = SPL_ST_TRAIN;
        end
      end
      SPL_ST_TRAIN:
      begin
        if (wait_cnt_reg == MAXWAIT_CYCLES - 1)
        begin
          train_fail = 1'b1;
          state_next = SPL_ST_DISABLE;
        end
        else if (master_reg && loc_rcvr_ok_in && rem_rcvr_ok_in)
        begin
          state_next = SPL_ST_IDLE_DATA;
        end
        // the count already holds one in the entry cycle
        else if (!master_reg && wait_cnt_reg >= MINWAIT_CYCLES)
        begin
          state_next = SPL_ST_SEND_IDLE;
        end
      end
      SPL_ST_SEND_IDLE:
      begin
        if (wait_cnt_reg == MAXWAIT_CYCLES - 1)
        begin
          train_fail = 1'b1;
          state_next = SPL_ST_DISABLE;
        end
        else if (rem_rcvr_ok_in)
        begin
          state_next = SPL_ST_IDLE_DATA;
        end
      end
      SPL_ST_IDLE_DATA:
      begin
        if (!loc_rcvr_ok_in)
        begin
          state_next = SPL_ST_DISABLE;
        end
      end
      default:
      begin
        state_next = SPL_ST_DISABLE;
      end
    endcase
    if (!link_en_reg)
    begin
      state_next = SPL_ST_DISABLE;
      train_fail = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= SPL_ST_DISABLE;
      wait_cnt_reg <= 32'h0000_0000;
      tx_mode_out <= SPL_TX_SEND_Z;
      training_failure_event_out <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      training_failure_event_out <= train_fail;
      if (state_next == SPL_ST_DISABLE || state_next == SPL_ST_IDLE_DATA)
      begin
        wait_cnt_reg <= 32'h0000_0000;
      end
      else
      begin
        wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
      end
      case (state_next)
        SPL_ST_TRAIN: tx_mode_out <= SPL_TX_SEND_I;
        SPL_ST_SEND_IDLE: tx_mode_out <= SPL_TX_SEND_I;
        SPL_ST_IDLE_DATA: tx_mode_out <= SPL_TX_SEND_N;
        default: tx_mode_out <= SPL_TX_SEND_Z;
      endcase
    end
  end

  // flags follow the receivers only while data may flow
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      loc_flag_reg <= 1'b0;
      rem_flag_reg <= 1'b0;
      scr_flag_reg <= 1'b0;
      link_up_out <= 1'b0;
      link_up_event_out <= 1'b0;
    end
    else
    begin
      loc_flag_reg <= state_next == SPL_ST_IDLE_DATA && loc_rcvr_ok_in;
      rem_flag_reg <= state_next == SPL_ST_IDLE_DATA && rem_rcvr_ok_in;
      scr_flag_reg <= state_next == SPL_ST_IDLE_DATA && descrambler_locked_in;
      link_up_out <= state_next == SPL_ST_IDLE_DATA;
      link_up_event_out <= state_next == SPL_ST_IDLE_DATA && !link_up_out;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      polarity_correct_out <= 1'b0;
    end
    else if (!master_reg && polarity_inverted_in &&
             (state_reg == SPL_ST_TRAIN || state_reg == SPL_ST_SEND_IDLE))
    begin
      polarity_correct_out <= 1'b1;
    end
    else if (!link_en_reg || master_reg)
    begin
      polarity_correct_out <= 1'b0;
    end
  end
endmodule

// ==== rtl/spl_cfg.svh ====
/*
  Constants for the single-pair link startup block: management register
  offsets, field positions, reset values and timing figures.
  Assumes a 40 MHz core clock and a clause 22 style management port.
*/
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

`define SPL_CLK_HZ 40_000_000
`define SPL_AUTO_EN_DELAY_MS 2
`define SPL_MINWAIT_CYCLES 4000
`define SPL_MAXWAIT_CYCLES 80000

`define SPL_REG_EXT_CTRL 5'h11
`define SPL_REG_COMM_STAT 5'h17

`define SPL_EXT_LINK_EN_BIT 15
`define SPL_EXT_MASTER_BIT 14
`define SPL_EXT_AUTONOMOUS_BIT 13

`define SPL_STAT_LINK_UP_BIT 15
`define SPL_STAT_LOC_OK_BIT 14
`define SPL_STAT_REM_OK_BIT 13
`define SPL_STAT_SCR_BIT 12
`define SPL_STAT_POL_BIT 11

`define SPL_RST_LINK_EN 1'b0
`define SPL_RST_MASTER 1'b0
`define SPL_RST_AUTONOMOUS 1'b1

`define SPL_PREAMBLE_ONES 6'h20
`define SPL_HDR_BITS 5'h0d
`define SPL_DATA_BITS 5'h10

`endif

// ==== rtl/spl_pkg.sv ====
/*
  Types for the single-pair link startup block.
  Assumes spl_cfg.svh holds the numeric constants.
*/
package spl_pkg;
  typedef enum logic [3:0] {
    SPL_ST_DISABLE = 4'b0001,
    SPL_ST_TRAIN = 4'b0010,
    SPL_ST_SEND_IDLE = 4'b0100,
    SPL_ST_IDLE_DATA = 4'b1000
  } spl_state_e;

  typedef enum logic [1:0] {
    SPL_TX_SEND_Z = 2'b00,
    SPL_TX_SEND_I = 2'b01,
    SPL_TX_SEND_N = 2'b10
  } spl_tx_mode_e;

  typedef enum logic [3:0] {
    SPL_SMI_PRE = 4'b0001,
    SPL_SMI_HDR = 4'b0010,
    SPL_SMI_RD = 4'b0100,
    SPL_SMI_WR = 4'b1000
  } spl_smi_state_e;
endpackage

// ==== rtl/spl_smi_slave.sv ====
/*
  Serial management frame slave: preamble, start, opcode, device and
  register address, turnaround and 16 data bits, MSB first.
  Assumes mdc_rise_in is a one-cycle pulse per synchronised rising edge of
  the management clock and mdio_bit_in the synchronised data level.
*/
`include "spl_cfg.svh"

module spl_smi_slave
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // serial side
  input wire logic mdc_rise_in,
  input wire logic mdio_bit_in,
  input wire logic [4:0] phy_addr_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // register side
  input wire logic [15:0] rd_data_in,
  output logic [4:0] reg_addr_out,
  output logic [15:0] wr_data_out,
  output logic wr_stb_out
);
  import spl_pkg::*;

  spl_smi_state_e state_reg;
  logic [5:0] ones_reg;
  logic [4:0] cnt_reg;
  logic [11:0] hdr_reg;
  logic [15:0] shift_reg;
  logic [12:0] hdr_full;

  assign hdr_full = {hdr_reg, mdio_bit_in};

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= SPL_SMI_PRE;
      ones_reg <= 6'h00;
      cnt_reg <= 5'h00;
      hdr_reg <= 12'h000;
      shift_reg <= 16'h0000;
      reg_addr_out <= 5'h00;
      wr_data_out <= 16'h0000;
      wr_stb_out <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_out <= 1'b0;
    end
    else
    begin
      wr_stb_out <= 1'b0;
      if (mdc_rise_in)
      begin
        case (state_reg)
          SPL_SMI_PRE:
          begin
            cnt_reg <= 5'h00;
            if (mdio_bit_in)
            begin
              if (ones_reg != `SPL_PREAMBLE_ONES)
              begin
                ones_reg <= ones_reg + 6'h01;
              end
            end
            else
            begin
              ones_reg <= 6'h00;
              if (ones_reg == `SPL_PREAMBLE_ONES)
              begin
                state_reg <= SPL_SMI_HDR;
              end
            end
          end
          SPL_SMI_HDR:
          begin
            hdr_reg <= hdr_full[11:0];
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `SPL_HDR_BITS - 5'h01)
            begin
              cnt_reg <= 5'h00;
              reg_addr_out <= hdr_full[4:0];
              // a frame for another device is skipped until the next preamble
              if (hdr_full[12] && hdr_full[9:5] == phy_addr_in && hdr_full[11:10] == 2'b10)
              begin
                state_reg <= SPL_SMI_RD;
              end
              else if (hdr_full[12] && hdr_full[9:5] == phy_addr_in &&
                       hdr_full[11:10] == 2'b01)
              begin
                state_reg <= SPL_SMI_WR;
              end
              else
              begin
                state_reg <= SPL_SMI_PRE;
              end
            end
          end
          SPL_SMI_RD:
          begin
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == 5'h00)
            begin
              // first turnaround bit seen: drive the zero, latch the word
              mdio_oe_out <= 1'b1;
              mdio_out <= 1'b0;
              shift_reg <= rd_data_in;
            end
            else if (cnt_reg <= `SPL_DATA_BITS)
            begin
              mdio_out <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
            end
            else
            begin
              mdio_oe_out <= 1'b0;
              mdio_out <= 1'b1;
              state_reg <= SPL_SMI_PRE;
            end
          end
          SPL_SMI_WR:
          begin
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg >= 5'h02)
            begin
              wr_data_out <= {wr_data_out[14:0], mdio_bit_in};
            end
            if (cnt_reg == `SPL_DATA_BITS + 5'h01)
            begin
              wr_stb_out <= 1'b1;
              state_reg <= SPL_SMI_PRE;
            end
          end
          default:
          begin
            state_reg <= SPL_SMI_PRE;
          end
        endcase
      end
    end
  end
endmodule

// ==== bench/spl_link_startup_properties.sv ====
/*
  Port-level properties of the link startup block.
  Assumes it is bound to spl_link_startup and sees only its ports.
*/
module spl_link_startup_checker
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // inputs watched
  input wire logic loc_rcvr_ok_in,
  input wire logic polarity_inverted_in,
  // outputs watched
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  input wire spl_pkg::spl_tx_mode_e tx_mode_out,
  input wire logic polarity_correct_out,
  input wire logic link_up_out,
  input wire logic link_up_event_out,
  input wire logic training_failure_event_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import spl_pkg::*;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_up_edge;
    !link_up_out ##1 link_up_out;
  endsequence
  sequence s_fail_once;
    training_failure_event_out ##1 !training_failure_event_out;
  endsequence
  AST_EVT_ON_RISE: assert property (s_up_edge |-> link_up_event_out)
    else $error("no link-up event on link up");
  AST_EVT_ONLY_RISE: assert property (link_up_event_out |-> link_up_out && !$past(link_up_out))
    else $error("link-up event without link rising");
  AST_FAIL_PULSE: assert property (training_failure_event_out |-> s_fail_once)
    else $error("training failure event longer than one cycle");
  AST_FAIL_NO_LINK: assert property (training_failure_event_out |-> !link_up_out)
    else $error("training failure while link up");
  AST_UP_SENDS_DATA: assert property (link_up_out |-> tx_mode_out == SPL_TX_SEND_N)
    else $error("link up without data transmit mode");
  AST_LOC_LOSS_DROPS: assert property (link_up_out && !loc_rcvr_ok_in |=> !link_up_out)
    else $error("link kept after local receiver loss");
  AST_MDIO_IDLE_HIGH: assert property (!mdio_oe_out |-> mdio_out)
    else $error("management data not idle high");
  AST_TA_DRIVES_ZERO: assert property ($rose(mdio_oe_out) |-> !mdio_out)
    else $error("turnaround not driven low");
  AST_POL_CAUSE: assert property ($rose(polarity_correct_out) |-> $past(polarity_inverted_in))
    else $error("polarity flag without inversion");
endmodule

// ==== bench/spl_remote_phy.sv ====
/*
  Behavioural remote link partner: raises receiver status levels a set
  number of cycles after the block starts transmitting.
  Assumes tx_mode_in is the block's transmit mode on the same clock.
*/
module spl_remote_phy
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // partner controls
  input wire logic en_in,
  input wire logic mute_in,
  input wire logic inv_in,
  input wire logic [7:0] dly_in,
  // line side
  input wire spl_pkg::spl_tx_mode_e tx_mode_in,
  output logic idle_sync_out,
  output logic loc_ok_out,
  output logic rem_ok_out,
  output logic scr_out,
  output logic pol_inv_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import spl_pkg::*;
  logic [7:0] cnt_reg;
  logic live;
  // a muted partner models a broken channel: nothing ever locks
  assign live = en_in && !mute_in;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_reg <= 8'h00;
    else if (!live || tx_mode_in == SPL_TX_SEND_Z)
      cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hff)
      cnt_reg <= cnt_reg + 8'h01;
  end
  assign idle_sync_out = live;
  assign loc_ok_out = live && cnt_reg > dly_in;
  assign rem_ok_out = live && cnt_reg > dly_in + 8'h02;
  assign scr_out = loc_ok_out;
  assign pol_inv_out = live && inv_in;
endmodule

// ==== bench/tb_top.sv ====
/*
  Self-checking bench: management frames bit-banged on the pins,
  remote partner model on the line side.
  Assumes the package, header and design are compiled first.
*/
`include "spl_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import spl_pkg::*;
  localparam int MINW = 5;
  localparam int MAXW = 200;
  localparam logic [4:0] PHY = 5'h04;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mdc_in = 1'b0;
  logic drv = 1'b1;
  logic drv_oe = 1'b0;
  logic normal_mode_in = 1'b0;
  logic p_en = 1'b1, p_mute = 1'b0, p_inv = 1'b1;
  logic [7:0] p_dly = 8'h01;
  logic mdio_in, mdio_out, mdio_oe_out, rx_idle_sync_in, loc_rcvr_ok_in;
  logic rem_rcvr_ok_in, descrambler_locked_in, polarity_inverted_in;
  logic polarity_correct_out, link_up_out, link_up_event_out, training_failure_event_out;
  spl_tx_mode_e tx_mode_out;
  int miscompares = 0;
  int checks = 0;
  // released line is pulled up
  assign mdio_in = mdio_oe_out ? mdio_out : (drv_oe ? drv : 1'b1);
  initial
    forever #12.5 core_clk_in = ~core_clk_in;
  spl_link_startup #(.AUTO_EN_CYCLES(20), .MINWAIT_CYCLES(MINW), .MAXWAIT_CYCLES(MAXW)) dut (
    .core_clk_in, .rst_n_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_out,
    .phy_addr_in(PHY), .normal_mode_in, .rx_idle_sync_in, .loc_rcvr_ok_in,
    .rem_rcvr_ok_in, .descrambler_locked_in, .polarity_inverted_in, .tx_mode_out,
    .polarity_correct_out, .link_up_out, .link_up_event_out, .training_failure_event_out);
  spl_remote_phy partner (.core_clk_in, .rst_n_in, .en_in(p_en), .mute_in(p_mute),
    .inv_in(p_inv), .dly_in(p_dly), .tx_mode_in(tx_mode_out), .idle_sync_out(rx_idle_sync_in),
    .loc_ok_out(loc_rcvr_ok_in), .rem_ok_out(rem_rcvr_ok_in),
    .scr_out(descrambler_locked_in), .pol_inv_out(polarity_inverted_in));
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #2;
  endtask
  // one management bit: 20 core clocks, sampled just before the rising edge
  task automatic smi_bit(input logic b, output logic s);
    drv = b;
    mdc_in = 1'b0;
    tick(10);
    s = mdio_in;
    mdc_in = 1'b1;
    tick(10);
  endtask
  task automatic smi(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, wr ? 2'b01 : 2'b10, pa, ra};
    drv_oe = 1'b1;
    repeat (32) smi_bit(1'b1, s);
    for (int i = 13; i >= 0; i--)
      smi_bit(hdr[i], s);
    drv_oe = wr;
    smi_bit(1'b1, s);
    smi_bit(1'b0, s);
    if (!wr)
      chk({15'h0000, s}, 16'h0000);
    for (int i = 15; i >= 0; i--)
      smi_bit(wd[i], rd[i]);
    drv_oe = 1'b0;
    smi_bit(1'b1, s);
  endtask
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] rd;
    smi(1'b1, PHY, ra, d, rd);
  endtask
  task automatic rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] rd;
    smi(1'b0, PHY, ra, 16'h0000, rd);
    chk(rd, exp);
  endtask
  task automatic wait_on(input int sel, input int lim, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim)
    begin
      tick(1);
      n++;
      case (sel)
        0: hit = link_up_out === 1'b1;
        1: hit = training_failure_event_out === 1'b1;
        default: hit = tx_mode_out === SPL_TX_SEND_I;
      endcase
    end
    if (!hit)
    begin
      miscompares++;
      final_report();
    end
  endtask
  initial
  begin
    int n;
    logic [15:0] rd;
    tick(10);
    rst_n_in = 1'b1;
    tick(2);
    rd_chk(`SPL_REG_EXT_CTRL, 16'h2000);
    rd_chk(`SPL_REG_COMM_STAT, 16'h0000);
    rd_chk(5'h05, 16'h0000);
    chk(16'(tx_mode_out), 16'(SPL_TX_SEND_Z));
    // slave, partner synced and inverted, enable set by the device itself
    normal_mode_in = 1'b1;
    p_en = 1'b0;
    tick(18);
    chk(16'(tx_mode_out), 16'(SPL_TX_SEND_Z));
    // enable is set by now, but with no idle sync the slave must stay silent
    tick(6);
    chk(16'(tx_mode_out), 16'(SPL_TX_SEND_Z));
    p_en = 1'b1;
    wait_on(2, 10, n);
    wait_on(0, 60, n);
    chk(16'(n > MINW), 16'h0001);
    chk({15'h0000, link_up_event_out}, 16'h0001);
    rd_chk(`SPL_REG_EXT_CTRL, 16'hA000);
    rd_chk(`SPL_REG_COMM_STAT, 16'hF800);
    smi(1'b1, 5'h03, `SPL_REG_EXT_CTRL, 16'h0000, rd);
    rd_chk(`SPL_REG_EXT_CTRL, 16'hA000);
    wr_reg(`SPL_REG_EXT_CTRL, 16'h2000);
    chk({15'h0000, link_up_out}, 16'h0000);
    chk(16'(tx_mode_out), 16'(SPL_TX_SEND_Z));
    rd_chk(`SPL_REG_COMM_STAT, 16'h0000);
    // master against a slow partner
    p_dly = 8'h28;
    wr_reg(`SPL_REG_EXT_CTRL, 16'hE000);
    wait_on(2, 10, n);
    wait_on(0, 80, n);
    chk({15'h0000, link_up_event_out}, 16'h0001);
    tick(1);
    chk({15'h0000, link_up_event_out}, 16'h0000);
    chk(16'(tx_mode_out), 16'(SPL_TX_SEND_N));
    rd_chk(`SPL_REG_COMM_STAT, 16'hF000);
    // channel breaks: link lost, training times out, then recovers
    p_mute = 1'b1;
    tick(3);
    chk({15'h0000, link_up_out}, 16'h0000);
    wait_on(1, MAXW + 20, n);
    wait_on(2, 5, n);
    p_mute = 1'b0;
    wait_on(0, MAXW + 20, n);
    final_report();
  end
endmodule
bind spl_link_startup spl_link_startup_checker chk_i (.core_clk_in, .rst_n_in,
  .loc_rcvr_ok_in, .polarity_inverted_in, .mdio_out, .mdio_oe_out, .tx_mode_out,
  .polarity_correct_out, .link_up_out, .link_up_event_out, .training_failure_event_out);
